// ===== rtl/sdt_regs.sv
`timescale 1ns/1ns
module sdt_regs #(
  parameter int TICK_SEL1_CYCLES = sdt_pkg::TICK_SEL1_CYC,
  parameter int TICK_SEL0_CYCLES = sdt_pkg::TICK_SEL0_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sdt_pkg::sdt_cmd_req_t cmd_req,
  output sdt_pkg::sdt_cmd_rsp_t cmd_rsp,
  input wire logic en_pin,
  input wire logic op_on,
  input wire logic off_cmd,
  input wire logic delay_tick_select,
  input wire logic [7:0] pin_temp_reading,
  input wire logic [7:0] die_temp_reading,
  input wire logic [3:0] address_strap_pin,
  output logic outputs_enabled,
  output logic [1:0] temp_over,
  output logic [1:0] temp_latched,
  output logic [6:0] slave_address
);

  logic [15:0] shutdown_delay_reg;
  logic [15:0] temp_cfg_reg [sdt_pkg::NUM_TEMP];
  logic [7:0] slave_address_cfg_reg;
  logic [1:0] en_sync_reg;
  logic [3:0] strap_meta_reg;
  logic [3:0] strap_sync_reg;
  logic [3:0] strap_sampled_reg;
  logic strap_taken_reg;
  logic [1:0] strap_fill_reg;
  logic [7:0] temp_reading [sdt_pkg::NUM_TEMP];
  sdt_pkg::sdt_state_t state_reg;
  logic [15:0] tick_div_reg;
  logic [23:0] delay_cnt_reg;
  logic tick;
  logic [15:0] tick_last;
  logic [23:0] delay_ticks;
  logic power_req;
  logic fault_hold;

  assign temp_reading[sdt_pkg::CH_PIN] = pin_temp_reading;
  assign temp_reading[sdt_pkg::CH_DIE] = die_temp_reading;

  // Command writes; the slave address byte keeps only its 8 bits
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      shutdown_delay_reg <= sdt_pkg::SHUTDOWN_DELAY_RST;
      temp_cfg_reg[sdt_pkg::CH_PIN] <= sdt_pkg::PIN_TEMP_LIMIT_RST;
      temp_cfg_reg[sdt_pkg::CH_DIE] <= sdt_pkg::DIE_TEMP_LIMIT_RST;
      slave_address_cfg_reg <= sdt_pkg::SLAVE_ADDRESS_RST;
    end
    else if (ce && cmd_req.wr)
    begin
      case (cmd_req.code)
        sdt_pkg::CMD_SHUTDOWN_DELAY: shutdown_delay_reg <= cmd_req.wdata;
        sdt_pkg::CMD_PIN_TEMP_LIMIT: temp_cfg_reg[sdt_pkg::CH_PIN] <= cmd_req.wdata;
        sdt_pkg::CMD_DIE_TEMP_LIMIT: temp_cfg_reg[sdt_pkg::CH_DIE] <= cmd_req.wdata;
        sdt_pkg::CMD_SLAVE_ADDRESS: slave_address_cfg_reg <= cmd_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Answer one cycle after the access; unknown codes are refused with nack
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cmd_rsp <= '0;
    end
    else if (ce)
    begin
      cmd_rsp.ack <= cmd_req.wr || cmd_req.rd;
      cmd_rsp.nack <= 1'b0;
      cmd_rsp.rdata <= sdt_pkg::READ_ZERO;
      if (cmd_req.wr || cmd_req.rd)
      begin
        case (cmd_req.code)
          sdt_pkg::CMD_SHUTDOWN_DELAY: cmd_rsp.rdata <= shutdown_delay_reg;
          sdt_pkg::CMD_PIN_TEMP_LIMIT: cmd_rsp.rdata <= temp_cfg_reg[sdt_pkg::CH_PIN];
          sdt_pkg::CMD_DIE_TEMP_LIMIT: cmd_rsp.rdata <= temp_cfg_reg[sdt_pkg::CH_DIE];
          sdt_pkg::CMD_SLAVE_ADDRESS: cmd_rsp.rdata <= {8'h00, slave_address_cfg_reg};
          default: cmd_rsp.nack <= 1'b1;
        endcase
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      en_sync_reg <= 2'b00;
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end
    else if (ce)
    begin
      en_sync_reg <= {en_sync_reg[0], en_pin};
      strap_meta_reg <= address_strap_pin;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Strap is sampled once, when two synchronised samples in a row agree;
  // the fill bits keep the synchroniser's reset zeros from passing as a strap value
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      strap_fill_reg <= 2'b00;
      strap_sampled_reg <= 4'h0;
      strap_taken_reg <= 1'b0;
    end
    else if (ce && !strap_taken_reg)
    begin
      strap_fill_reg <= {strap_fill_reg[0], 1'b1};
      if (strap_fill_reg[1])
      begin
        strap_sampled_reg <= strap_sync_reg;
        strap_taken_reg <= strap_sampled_reg == strap_sync_reg;
      end
    end
  end

  // Final slave address
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      slave_address <= sdt_pkg::SLAVE_ADDRESS_RST[6:0];
    end
    else if (ce)
    begin
      slave_address[sdt_pkg::ADDR_HI_MSB:sdt_pkg::ADDR_HI_LSB] <=
        slave_address_cfg_reg[sdt_pkg::ADDR_HI_MSB:sdt_pkg::ADDR_HI_LSB];
      if (slave_address_cfg_reg[sdt_pkg::ADDR_STRAP_SEL_BIT])
        slave_address[sdt_pkg::ADDR_LO_MSB:sdt_pkg::ADDR_LO_LSB] <= strap_sampled_reg;
      else
        slave_address[sdt_pkg::ADDR_LO_MSB:sdt_pkg::ADDR_LO_LSB] <=
          slave_address_cfg_reg[sdt_pkg::ADDR_LO_MSB:sdt_pkg::ADDR_LO_LSB];
    end
  end

  // Over-temperature comparators with hysteresis, one per channel
  for (genvar ch = 0; ch < sdt_pkg::NUM_TEMP; ch++)
  begin : g_temp
    logic [7:0] limit;
    logic [6:0] hys;
    logic signed [9:0] release_lvl;
    assign limit = temp_cfg_reg[ch][sdt_pkg::TEMP_LIM_MSB:sdt_pkg::TEMP_LIM_LSB];
    assign hys = temp_cfg_reg[ch][sdt_pkg::TEMP_HYS_MSB:sdt_pkg::TEMP_HYS_LSB];
    // Signed so a hysteresis above the limit never wraps into a high threshold
    assign release_lvl = $signed({2'b00, limit}) - $signed({3'b000, hys});

    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        temp_over[ch] <= 1'b0;
      end
      else if (ce)
      begin
        if (temp_reading[ch] > limit)
          temp_over[ch] <= 1'b1;
        else if ($signed({2'b00, temp_reading[ch]}) <= release_lvl)
          temp_over[ch] <= 1'b0;
      end
    end

    // Latch-off holds until the power request is withdrawn
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        temp_latched[ch] <= 1'b0;
      end
      else if (ce)
      begin
        if (temp_over[ch] && temp_cfg_reg[ch][sdt_pkg::TEMP_LATCH_BIT])
          temp_latched[ch] <= 1'b1;
        else if (!power_req)
          temp_latched[ch] <= 1'b0;
      end
    end
  end

  // Hiccup retries as soon as the comparator drops; latch-off waits for a re-enable
  assign fault_hold = |temp_over || |temp_latched;
  assign power_req = en_sync_reg[1] && op_on;

  // Delay tick prescaler, period chosen by the tick select
  assign tick_last = delay_tick_select ? 16'(TICK_SEL1_CYCLES - 1) : 16'(TICK_SEL0_CYCLES - 1);
  assign tick = tick_div_reg >= tick_last;
  assign delay_ticks = (24'(shutdown_delay_reg[sdt_pkg::DLY_HI_MSB:sdt_pkg::DLY_HI_LSB])
    << sdt_pkg::DLY_HI_SHIFT)
    + 24'(shutdown_delay_reg[sdt_pkg::DLY_LO_MSB:sdt_pkg::DLY_LO_LSB]);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tick_div_reg <= 16'h0000;
    else if (ce)
      tick_div_reg <= (state_reg != sdt_pkg::ST_OFF_WAIT || tick) ? 16'h0000
        : tick_div_reg + 16'h0001;
  end

  // Power sequencing: a fault shuts at once, an off request waits the delay
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= sdt_pkg::ST_OFF;
      delay_cnt_reg <= 24'h00_0000;
    end
    else if (ce)
    begin
      case (state_reg)
        sdt_pkg::ST_OFF:
        begin
          if (power_req && !fault_hold)
            state_reg <= sdt_pkg::ST_RUN;
        end
        sdt_pkg::ST_RUN:
        begin
          delay_cnt_reg <= 24'h00_0000;
          if (fault_hold)
            state_reg <= sdt_pkg::ST_OFF;
          else if (!power_req || off_cmd)
            state_reg <= (delay_ticks == 24'h00_0000) ? sdt_pkg::ST_OFF
              : sdt_pkg::ST_OFF_WAIT;
        end
        sdt_pkg::ST_OFF_WAIT:
        begin
          if (fault_hold || delay_cnt_reg + 24'h00_0001 >= delay_ticks && tick)
            state_reg <= sdt_pkg::ST_OFF;
          else if (tick)
            delay_cnt_reg <= delay_cnt_reg + 24'h00_0001;
        end
        default: state_reg <= sdt_pkg::ST_OFF;
      endcase
    end
  end

  // Reference ramp, power good and PWM stay enabled through the off delay
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      outputs_enabled <= 1'b0;
    else if (ce)
      outputs_enabled <= state_reg == sdt_pkg::ST_RUN
        || state_reg == sdt_pkg::ST_OFF_WAIT;
  end

endmodule // sdt_regs

// ===== rtl/sdt_pkg.sv
package sdt_pkg;

  // Command codes of the register group
  localparam logic [7:0] CMD_SHUTDOWN_DELAY = 8'h64;
  localparam logic [7:0] CMD_PIN_TEMP_LIMIT = 8'h65;
  localparam logic [7:0] CMD_DIE_TEMP_LIMIT = 8'h66;
  localparam logic [7:0] CMD_SLAVE_ADDRESS = 8'h67;

  // Field positions
  localparam int DLY_HI_MSB = 15;
  localparam int DLY_HI_LSB = 8;
  localparam int DLY_LO_MSB = 7;
  localparam int DLY_LO_LSB = 0;
  localparam int TEMP_LATCH_BIT = 15;
  localparam int TEMP_HYS_MSB = 14;
  localparam int TEMP_HYS_LSB = 8;
  localparam int TEMP_LIM_MSB = 7;
  localparam int TEMP_LIM_LSB = 0;
  localparam int ADDR_STRAP_SEL_BIT = 7;
  localparam int ADDR_HI_MSB = 6;
  localparam int ADDR_HI_LSB = 4;
  localparam int ADDR_LO_MSB = 3;
  localparam int ADDR_LO_LSB = 0;

  // Shift that turns the delay high byte into 256 ticks per count
  localparam int DLY_HI_SHIFT = 8;

  // Reset values
  localparam logic [15:0] SHUTDOWN_DELAY_RST = 16'h0000;
  localparam logic [15:0] PIN_TEMP_LIMIT_RST = 16'h0A7D;
  localparam logic [15:0] DIE_TEMP_LIMIT_RST = 16'h0A7D;
  localparam logic [7:0] SLAVE_ADDRESS_RST = 8'h20;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Delay tick periods and clock rate
  localparam int CLK_MHZ = 100;
  localparam int TICK_SEL1_US = 50;
  localparam int TICK_SEL0_US = 20;
  localparam int TICK_SEL1_CYC = TICK_SEL1_US * CLK_MHZ;
  localparam int TICK_SEL0_CYC = TICK_SEL0_US * CLK_MHZ;

  // Temperature channels: pin and die
  localparam int NUM_TEMP = 2;
  localparam int CH_PIN = 0;
  localparam int CH_DIE = 1;

  // Power sequencing states, Gray along off -> run -> delay
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_OFF_WAIT = 2'b11
  } sdt_state_t;

  // Command access from the bus protocol engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } sdt_cmd_req_t;

  // Answer to a command access
  typedef struct packed {
    logic ack;
    logic nack;
    logic [15:0] rdata;
  } sdt_cmd_rsp_t;

endpackage

// ===== verification/sdt_host_model.sv
`timescale 1ns/1ns
module sdt_host_model (
  input wire logic mclk,
  output sdt_pkg::sdt_cmd_req_t cmd_req,
  input wire sdt_pkg::sdt_cmd_rsp_t cmd_rsp
);
  // Strobes idle low from time zero
  initial cmd_req = '0;
  // One access: strobe one cycle, answer taken while it stands
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                        output sdt_pkg::sdt_cmd_rsp_t rsp);
    @(negedge mclk);
    cmd_req <= '{wr: wr, rd: !wr, code: code, wdata: wdata};
    @(negedge mclk);
    rsp = cmd_rsp;
    // Released code and data show the inverse, so a stale copy never passes
    cmd_req <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata};
  endtask
endmodule // sdt_host_model

// ===== verification/sdt_regs_checker.sv
`timescale 1ns/1ns
module sdt_regs_checker #(
  parameter int TICK_SEL1_CYCLES = 4,
  parameter int TICK_SEL0_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sdt_pkg::sdt_cmd_req_t cmd_req,
  input wire logic off_cmd,
  input wire logic [7:0] pin_temp_reading,
  input wire logic [7:0] die_temp_reading,
  input wire logic outputs_enabled,
  input wire logic [1:0] temp_over,
  input wire logic [1:0] temp_latched,
  input wire logic [6:0] slave_address
);
  logic [15:0] dly_reg, pin_reg, die_reg;
  logic pin_cool, die_cool, long_dly, addr_wr;
  // Shadow settings, kept because the stored registers are not ports
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dly_reg <= sdt_pkg::SHUTDOWN_DELAY_RST;
      pin_reg <= sdt_pkg::PIN_TEMP_LIMIT_RST;
      die_reg <= sdt_pkg::DIE_TEMP_LIMIT_RST;
    end
    else if (ce && cmd_req.wr)
    begin
      if (cmd_req.code == sdt_pkg::CMD_SHUTDOWN_DELAY) dly_reg <= cmd_req.wdata;
      if (cmd_req.code == sdt_pkg::CMD_PIN_TEMP_LIMIT) pin_reg <= cmd_req.wdata;
      if (cmd_req.code == sdt_pkg::CMD_DIE_TEMP_LIMIT) die_reg <= cmd_req.wdata;
    end
  end
  // Signed sums: a hysteresis above the limit must never clear
  assign pin_cool = int'(pin_temp_reading) <= int'(pin_reg[7:0]) - int'(pin_reg[14:8]);
  assign die_cool = int'(die_temp_reading) <= int'(die_reg[7:0]) - int'(die_reg[14:8]);
  assign long_dly = int'(dly_reg) * TICK_SEL0_CYCLES > 9 + TICK_SEL1_CYCLES * 0;
  assign addr_wr = ce && cmd_req.wr && cmd_req.code == sdt_pkg::CMD_SLAVE_ADDRESS;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_held;
    outputs_enabled [*8];
  endsequence
  addr_direct_a: assert property (addr_wr && !cmd_req.wdata[7] |-> ##2
    slave_address == $past(cmd_req.wdata[6:0], 2)) else $error("direct address wrong");
  addr_strap_a: assert property (addr_wr && cmd_req.wdata[7] |-> ##2
    slave_address[6:4] == $past(cmd_req.wdata[6:4], 2)) else $error("address top bits wrong");
  pin_trip_a: assert property (ce && pin_temp_reading > pin_reg[7:0] |=>
    temp_over[0]) else $error("pin over-temperature missed");
  die_trip_a: assert property (ce && die_temp_reading > die_reg[7:0] |=>
    temp_over[1]) else $error("die over-temperature missed");
  pin_clear_a: assert property (ce && pin_cool |=> !temp_over[0])
    else $error("pin comparator did not clear");
  die_clear_a: assert property (ce && die_cool |=> !temp_over[1])
    else $error("die comparator did not clear");
  pin_hiccup_a: assert property (ce && !pin_reg[15] && !temp_latched[0] |=>
    !temp_latched[0]) else $error("pin latched in hiccup mode");
  die_hiccup_a: assert property (ce && !die_reg[15] && !temp_latched[1] |=>
    !temp_latched[1]) else $error("die latched in hiccup mode");
  // A latched fault also shuts at once, so it is kept out of the antecedent
  off_hold_a: assert property (ce && long_dly && outputs_enabled && off_cmd &&
    temp_over == 2'b00 && temp_latched == 2'b00 |=> s_held)
    else $error("outputs dropped before off delay");
endmodule // sdt_regs_checker

// ===== verification/tb_sdt_regs.sv
`timescale 1ns/1ns
module tb_sdt_regs;
  typedef struct packed {
    logic [7:0] code;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } sdt_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic en_pin = 1'b1;
  logic op_on = 1'b1;
  logic off_cmd = 1'b0;
  logic tick_sel = 1'b0;
  logic [7:0] pin_t = 8'h00;
  logic [7:0] die_t = 8'h00;
  logic [3:0] strap = 4'hA;
  sdt_pkg::sdt_cmd_req_t cmd_req;
  sdt_pkg::sdt_cmd_rsp_t cmd_rsp, rsp;
  logic outputs_enabled;
  logic [1:0] temp_over, temp_latched;
  logic [6:0] slave_address;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int n = 0;
  // Write then read back; the upper byte of the address word reads zero
  sdt_row_t rows [5] = '{'{8'h64, 16'hA5C3, 16'hA5C3}, '{8'h65, 16'hFFFF, 16'hFFFF},
    '{8'h66, 16'h7F00, 16'h7F00}, '{8'h67, 16'hBE81, 16'h0081}, '{8'h68, 16'h1234, 16'h0000}};
  logic [15:0] rst_exp [4] = '{sdt_pkg::SHUTDOWN_DELAY_RST, sdt_pkg::PIN_TEMP_LIMIT_RST,
    sdt_pkg::DIE_TEMP_LIMIT_RST, 16'(sdt_pkg::SLAVE_ADDRESS_RST)};
  sdt_regs #(.TICK_SEL1_CYCLES(4), .TICK_SEL0_CYCLES(2)) uut (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .en_pin(en_pin), .op_on(op_on),
    .off_cmd(off_cmd), .delay_tick_select(tick_sel), .pin_temp_reading(pin_t),
    .die_temp_reading(die_t), .address_strap_pin(strap), .outputs_enabled(outputs_enabled),
    .temp_over(temp_over), .temp_latched(temp_latched), .slave_address(slave_address));
  sdt_host_model host (.mclk(mclk), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));
  // Clock and a hang guard well above the longest off delay
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Bounded wait for the outputs to reach a level; n keeps the cycles spent
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (outputs_enabled !== v && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    chk(16'(outputs_enabled), 16'(v));
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      host.access(1'b1, rows[i].code, rows[i].wdata, rsp);
      chk(16'({rsp.ack, rsp.nack}), 16'({1'b1, rows[i].code > 8'h67}));
      host.access(1'b0, rows[i].code, 16'h0000, rsp);
      chk(rsp.rdata, rows[i].rdata);
    end
    $display("done: register table");
    // Mid-run reset restores every setting
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    chk(16'(slave_address), 16'(sdt_pkg::SLAVE_ADDRESS_RST[6:0]));
    for (int k = 0; k < 4; k++)
    begin
      host.access(1'b0, 8'h64 + 8'(k), 16'h0000, rsp);
      chk(rsp.rdata, rst_exp[k]);
    end
    host.access(1'b1, sdt_pkg::CMD_SLAVE_ADDRESS, 16'h0055, rsp);
    @(negedge mclk);
    chk(16'(slave_address), 16'h0055);
    host.access(1'b1, sdt_pkg::CMD_SLAVE_ADDRESS, 16'h00C5, rsp);
    @(negedge mclk);
    chk(16'(slave_address), 16'h004A);
    // Clock enable low: the write is ignored and no answer comes
    ce = 1'b0;
    host.access(1'b1, sdt_pkg::CMD_SHUTDOWN_DELAY, 16'h1234, rsp);
    ce = 1'b1;
    chk(16'(rsp.ack), 16'h0000);
    host.access(1'b0, sdt_pkg::CMD_SHUTDOWN_DELAY, 16'h0000, rsp);
    chk(rsp.rdata, sdt_pkg::SHUTDOWN_DELAY_RST);
    $display("done: reset and address");
    // Pin in hiccup, limit 100 less 5; die latched, limit 50 less 3
    host.access(1'b1, sdt_pkg::CMD_PIN_TEMP_LIMIT, 16'h0564, rsp);
    host.access(1'b1, sdt_pkg::CMD_DIE_TEMP_LIMIT, 16'h8332, rsp);
    wait_oe(1'b1, 50);
    pin_t = 8'h65;
    // Comparator, then the state machine, then the registered enable: three edges
    repeat (3) @(negedge mclk);
    chk(16'({outputs_enabled, temp_over, temp_latched}), 16'h0004);
    pin_t = 8'h60;
    repeat (2) @(negedge mclk);
    chk(16'(temp_over), 16'h0001);
    pin_t = 8'h5F;
    repeat (2) @(negedge mclk);
    chk(16'(temp_over), 16'h0000);
    wait_oe(1'b1, 50);
    die_t = 8'h33;
    repeat (2) @(negedge mclk);
    chk(16'({temp_over, temp_latched}), 16'h000A);
    die_t = 8'h2F;
    repeat (4) @(negedge mclk);
    chk(16'({outputs_enabled, temp_over, temp_latched}), 16'h0002);
    op_on = 1'b0;
    repeat (2) @(negedge mclk);
    op_on = 1'b1;
    wait_oe(1'b1, 50);
    $display("done: temperature");
    // Off delay of 259 ticks: bus command at the short tick, pin at the long one
    host.access(1'b1, sdt_pkg::CMD_SHUTDOWN_DELAY, 16'h0103, rsp);
    for (int k = 0; k < 2; k++)
    begin
      tick_sel = k[0];
      @(negedge mclk);
      if (k == 0) off_cmd = 1'b1;
      else en_pin = 1'b0;
      @(negedge mclk);
      off_cmd = 1'b0;
      wait_oe(1'b0, 2000);
      chk(16'(n >= 259 * (k + 1) * 2 - 2 && n <= 259 * (k + 1) * 2 + 5), 16'h0001);
      en_pin = 1'b1;
      wait_oe(1'b1, 50);
    end
    $display("done: off delay");
    stop_test();
  end
endmodule // tb_sdt_regs
bind sdt_regs sdt_regs_checker #(.TICK_SEL1_CYCLES(TICK_SEL1_CYCLES),
  .TICK_SEL0_CYCLES(TICK_SEL0_CYCLES)) chk_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .cmd_req(cmd_req), .off_cmd(off_cmd), .pin_temp_reading(pin_temp_reading),
  .die_temp_reading(die_temp_reading), .outputs_enabled(outputs_enabled),
  .temp_over(temp_over), .temp_latched(temp_latched), .slave_address(slave_address));
